//--- igs_pkg.sv
// constants shared by the line sequencer and its return memory
// assumes a single 25 MHz clock domain
package igs_pkg;
  // command opcodes
  localparam logic [7:0] OP_WR_LOW = 8'h80;
  localparam logic [7:0] OP_RD_LOW = 8'h81;
  localparam logic [7:0] OP_WR_HIGH = 8'h82;
  localparam logic [7:0] OP_RD_HIGH = 8'h83;
  localparam logic [7:0] OP_SEND_IMM = 8'h87;
  // pin reset values: all released, value low
  localparam logic [7:0] PIN_VAL_RST = 8'h00;
  localparam logic [7:0] PIN_OE_N_RST = 8'hFF;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int LATENCY_MS = 16;
  localparam int LATENCY_CYC = LATENCY_MS * (CLK_HZ / 1000);
  localparam int HOLD_NS = 80;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (HOLD_NS * CLK_MHZ + 999) / 1000;
  // return buffering
  localparam int RET_DEPTH = 512;
  localparam int FULL_PACKET = 510;
  typedef enum logic [1:0] {S_OP, S_VAL, S_DIR, S_HOLD} igs_state_t;
endpackage

//--- igs_return_ram.sv
// return byte memory: one write port, one read port, registered read data
// assumes the caller never writes a slot it has not yet read back
`timescale 1ns/1ns
module igs_return_ram #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data holds until the next read, so it can sit on a stalled output
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

//--- igs_line_sequencer.sv
// byte command engine driving the low and high pin ports, with a return path
// assumes commands arrive on a valid/ready byte stream from the host side
// Notes on behaviour
// - after a start, lines rest with SDA released and SCL low.
// - emulated open drain: value low, direction selects drive or release.
// - low-port write sets all eight pins from value and direction bytes.
// - direction bit one makes an output, zero an input.
// - low-port read samples the eight pins and returns the byte.
// - high-port write takes value then direction, setting eight pins.
// - high value reaches a pin only when its direction bit is one.
// - high-port writes never disturb the low-port I2C lines.
// - high-port read returns sampled pins promptly after send-immediate.
// - only high-port bits zero to seven are controlled and sampled.
// - without a high port its write and read commands are unsupported.
// - send-immediate flushes all captured bytes back without waiting.
// - otherwise flush on 510 buffered bytes or latency timer expiry.
`timescale 1ns/1ns
module igs_line_sequencer
  import igs_pkg::*;
#(
  parameter int LATENCY_CYCLES = igs_pkg::LATENCY_CYC,
  parameter bit HAS_HIGH_PORT = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // command stream from host
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // return stream to host
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // low port pins: bit0 SCL, bit1 SDA out, bit2 SDA in, bits 7:3 spare
  input wire logic [7:0] low_port_pins_in,
  output logic [7:0] low_port_pins_out,
  output logic [7:0] low_port_pins_oe_n,
  // high port pins, bits 7:0 only
  input wire logic [7:0] high_port_pins_in,
  output logic [7:0] high_port_pins_out,
  output logic [7:0] high_port_pins_oe_n,
  // status
  output logic bad_cmd
);
  import igs_pkg::*;

  localparam int AW = $clog2(RET_DEPTH);
  localparam int CW = AW + 1;
  localparam int LW = $clog2(LATENCY_CYCLES + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(RET_DEPTH);
  localparam logic [CW-1:0] CNT_PACKET = CW'(FULL_PACKET);
  localparam logic [LW-1:0] LAT_LAST = LW'(LATENCY_CYCLES - 1);
  localparam logic [3:0] HOLD_LOAD = 4'(HOLD_CYC);

  igs_state_t state_r, state_nxt;
  logic [7:0] op_r, val_r;
  logic [3:0] hold_r;
  logic [7:0] low_s1_r, low_s2_r, high_s1_r, high_s2_r;
  logic [7:0] low_out_r, low_oe_n_r, high_out_r, high_oe_n_r;
  logic [CW-1:0] count_r, count_nxt;
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [LW-1:0] lat_r;
  logic flush_r, flush_nxt;
  logic cmd_ready_r, rsp_valid_r, bad_cmd_r;

  // decode of the accepted byte
  wire accept = cmd_valid && cmd_ready_r;
  wire at_op = accept && (state_r == S_OP);
  wire is_wr = (cmd_data == OP_WR_LOW) || (cmd_data == OP_WR_HIGH);
  wire rd_low = at_op && (cmd_data == OP_RD_LOW);
  wire rd_high = at_op && (cmd_data == OP_RD_HIGH) && HAS_HIGH_PORT;
  wire send_imm = at_op && (cmd_data == OP_SEND_IMM);
  wire unknown = at_op && !is_wr && !rd_low && !rd_high && !send_imm;
  wire apply = accept && (state_r == S_DIR);
  wire apply_low = apply && (op_r == OP_WR_LOW);
  wire apply_high = apply && (op_r == OP_WR_HIGH) && HAS_HIGH_PORT;

  // return path
  wire push = rd_low || rd_high;
  wire [7:0] push_data = rd_high ? high_s2_r : low_s2_r;
  wire issue = flush_r && (count_r != '0) && (!rsp_valid_r || rsp_ready);
  wire lat_expired = (lat_r == LAT_LAST);
  wire flush_set = send_imm || (count_r >= CNT_PACKET) || lat_expired;

  always_comb begin
    count_nxt = count_r + CW'(push) - CW'(issue);
    // a new trigger beats the end-of-drain clear
    if (flush_set) begin
      flush_nxt = 1'b1;
    end else if (count_nxt == '0) begin
      flush_nxt = 1'b0;
    end else begin
      flush_nxt = flush_r;
    end
  end

  // sequencing, one command at a time in arrival order
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OP: begin
        if (at_op && is_wr) begin
          state_nxt = S_VAL;
        end
      end
      S_VAL: begin
        if (accept) begin
          state_nxt = S_DIR;
        end
      end
      S_DIR: begin
        if (accept) begin
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        if (hold_r <= 4'h1) begin
          state_nxt = S_OP;
        end
      end
      default: state_nxt = S_OP;
    endcase
  end

  // pin synchronisers; only the second stage is ever sampled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_s1_r <= 8'h00;
      low_s2_r <= 8'h00;
      high_s1_r <= 8'h00;
      high_s2_r <= 8'h00;
    end else begin
      low_s1_r <= low_port_pins_in;
      low_s2_r <= low_s1_r;
      high_s1_r <= high_port_pins_in;
      high_s2_r <= high_s1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_OP;
      op_r <= 8'h00;
      val_r <= 8'h00;
      hold_r <= 4'h0;
      cmd_ready_r <= 1'b0;
      bad_cmd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (at_op) begin
        op_r <= cmd_data;
      end
      if (accept && state_r == S_VAL) begin
        val_r <= cmd_data;
      end
      hold_r <= apply ? HOLD_LOAD : (hold_r != 4'h0 ? hold_r - 4'h1 : 4'h0);
      // no byte is taken while a pin state is being held or the buffer is full
      cmd_ready_r <= (state_nxt != S_HOLD) && (count_nxt != CNT_FULL);
      bad_cmd_r <= unknown || (at_op && cmd_data == OP_RD_HIGH && !HAS_HIGH_PORT);
    end
  end

  // pin drivers: a pin is released by clearing its direction bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_out_r <= PIN_VAL_RST;
      low_oe_n_r <= PIN_OE_N_RST;
      high_out_r <= PIN_VAL_RST;
      high_oe_n_r <= PIN_OE_N_RST;
    end else begin
      if (apply_low) begin
        low_out_r <= val_r;
        low_oe_n_r <= ~cmd_data;
      end
      if (apply_high) begin
        high_out_r <= val_r;
        high_oe_n_r <= ~cmd_data;
      end
    end
  end

  // return buffer bookkeeping and latency timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      flush_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      lat_r <= '0;
    end else begin
      count_r <= count_nxt;
      flush_r <= flush_nxt;
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (issue) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      rsp_valid_r <= issue ? 1'b1 : (rsp_ready ? 1'b0 : rsp_valid_r);
      // the timer only runs while bytes wait and no flush is under way
      lat_r <= (count_r != '0 && !flush_r && !lat_expired) ? lat_r + LW'(1) : '0;
    end
  end

  igs_return_ram #(
    .DEPTH(RET_DEPTH),
    .AW(AW)
  ) u_ram (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wr_ptr_r),
    .wr_data(push_data),
    .rd_en(issue),
    .rd_addr(rd_ptr_r),
    .rd_data(rsp_data)
  );

  assign cmd_ready = cmd_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign low_port_pins_out = low_out_r;
  assign low_port_pins_oe_n = low_oe_n_r;
  assign high_port_pins_out = high_out_r;
  assign high_port_pins_oe_n = high_oe_n_r;
  assign bad_cmd = bad_cmd_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_low_write;
    accept && state_r == S_DIR && op_r == OP_WR_LOW;
  endsequence

  property p_low_write;
    apply_low |=> low_port_pins_out == $past(val_r) && low_port_pins_oe_n == ~$past(cmd_data);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low port not updated from command");

  property p_low_seq;
    s_low_write |=> low_port_pins_oe_n == ~$past(cmd_data) && state_r == S_HOLD;
  endproperty
  a_low_seq: assert property (p_low_seq) else $error("low write sequence not applied");

  property p_high_write;
    apply_high |=> high_port_pins_out == $past(val_r) && high_port_pins_oe_n == ~$past(cmd_data);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high port not updated");

  property p_high_spares_low;
    apply_high |=> $stable(low_port_pins_out) && $stable(low_port_pins_oe_n);
  endproperty
  a_high_spares_low: assert property (p_high_spares_low) else $error("high write moved low port");

  property p_pins_steady;
    !apply |=> $stable(low_port_pins_out) && $stable(low_port_pins_oe_n);
  endproperty
  a_pins_steady: assert property (p_pins_steady) else $error("low port changed without a write");

  property p_read_push;
    (rd_low || rd_high) && !issue |=> count_r == $past(count_r) + CW'(1);
  endproperty
  a_read_push: assert property (p_read_push) else $error("sampled byte not captured");

  property p_send_imm;
    send_imm |=> flush_r ##1 (count_r == '0 || rsp_valid);
  endproperty
  a_send_imm: assert property (p_send_imm) else $error("send-immediate did not flush");

  property p_packet_flush;
    count_r >= CNT_PACKET || lat_expired |=> flush_r;
  endproperty
  a_packet_flush: assert property (p_packet_flush) else $error("full packet or timer did not flush");

  property p_hold;
    apply |=> !cmd_ready ##1 !cmd_ready;
  endproperty
  a_hold: assert property (p_hold) else $error("pin state not held");

  property p_no_high;
    !HAS_HIGH_PORT |-> high_port_pins_oe_n == PIN_OE_N_RST;
  endproperty
  a_no_high: assert property (p_no_high) else $error("high port driven without a high port");
endmodule

//--- placeholder_end.sv
`timescale 1ns/1ns

//--- igs_pin_model.sv
// pins outside the sequencer: pulled-up open-drain i2c wires plus external sources
// assumes the sequencer drives a pin only while its oe_n bit is low
`timescale 1ns/1ns
module igs_pin_model (
  // sequencer drive
  input wire logic [7:0] low_out,
  input wire logic [7:0] low_oe_n,
  input wire logic [7:0] high_out,
  input wire logic [7:0] high_oe_n,
  // external level on undriven high pins
  input wire logic [7:0] high_ext,
  // levels seen back at the sequencer
  output logic [7:0] low_in,
  output logic [7:0] high_in
);
  // a released low pin floats to its pull-up, so a stale value never leaks back
  assign low_in = low_oe_n | low_out;
  // only the eight high pins exist here; bits beyond belong to other functions
  assign high_in = (high_oe_n & high_ext) | (~high_oe_n & high_out);
endmodule

//--- igs_line_sequencer_tb.sv
// self-checking bench for the line sequencer with a pin model on its far side
// assumes the design files and igs_pkg are compiled first
`timescale 1ns/1ns
module igs_line_sequencer_tb;
  import igs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic rsp_ready = 1'b0;
  logic [7:0] hi_ext = 8'h00;
  logic cmd_ready, rsp_valid, bad_cmd;
  logic [7:0] rsp_data, lo_in, lo_out, lo_oe_n, hi_in, hi_out, hi_oe_n;
  logic [15:0] lfsr = 16'hC178;
  logic [15:0] stall_lfsr = 16'hC178;
  logic [7:0] last_rsp = 8'h00;
  logic [7:0] lv = 8'h00, ld = 8'h00, hv = 8'h00, hd = 8'h00;
  logic [7:0] exp_q[$];
  // idle, start, held, repeated start, held, stop
  logic [2:0] seq [11] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h0, 3'h2, 3'h3, 3'h1, 3'h3, 3'h2, 3'h0};
  int err_count = 0;
  int samples_checked = 0;

  igs_line_sequencer #(.LATENCY_CYCLES(50), .HAS_HIGH_PORT(1'b1)) dut (
    .clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .low_port_pins_in(lo_in), .low_port_pins_out(lo_out), .low_port_pins_oe_n(lo_oe_n),
    .high_port_pins_in(hi_in), .high_port_pins_out(hi_out), .high_port_pins_oe_n(hi_oe_n),
    .bad_cmd(bad_cmd));

  igs_pin_model pins (
    .low_out(lo_out), .low_oe_n(lo_oe_n), .high_out(hi_out), .high_oe_n(hi_oe_n),
    .high_ext(hi_ext), .low_in(lo_in), .high_in(hi_in));

  always #20 clk = ~clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hold the byte until the edge that samples ready high
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_data = b;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) err_count++;
    #1;
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] v, input logic [7:0] d);
    send(op);
    send(v);
    send(d);
    cmd_valid = 1'b0;
    @(posedge clk);
    #1;
    if (op == OP_WR_LOW) begin
      lv = v;
      ld = d;
    end else begin
      hv = v;
      hd = d;
    end
    chk("low_out", lo_out, lv);
    chk("low_oe_n", lo_oe_n, ~ld);
    chk("high_out_driven", hi_out & hd, hv & hd);
    chk("high_oe_n", hi_oe_n, ~hd);
    chk("cmd_ready_hold", {7'h00, cmd_ready}, 8'h00);
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] e, input bit imm);
    int n;
    // pin samples lag the pins by two synchroniser stages
    repeat (2) @(posedge clk);
    #1;
    exp_q.push_back(e);
    send(op);
    if (imm) send(OP_SEND_IMM);
    cmd_valid = 1'b0;
    if (!imm) begin
      repeat (10) @(posedge clk);
      #1;
      chk("early_return", {7'h00, rsp_valid}, 8'h00);
    end
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      n++;
      @(posedge clk);
    end
    #1;
    chk("pending_returns", 8'(exp_q.size()), 8'h00);
  endtask

  // random stalls on the return side
  always @(posedge clk) begin
    #1;
    // own generator, so stalls keep changing while the main sequence waits
    stall_lfsr = lfsr_next(stall_lfsr);
    rsp_ready = stall_lfsr[0] | stall_lfsr[5];
  end

  // return monitor: oldest note is compared to each accepted byte
  always @(posedge clk) begin
    if (reset_n && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected rsp_data: expected none, seen %h", rsp_data);
      end else begin
        last_rsp = rsp_data;
        chk("rsp_data", rsp_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    #(40 * 20000);
    err_count++;
    wrap_up();
  end

  initial begin
    int k;
    repeat (4) @(posedge clk);
    #1;
    chk("reset_low_oe_n", lo_oe_n, PIN_OE_N_RST);
    chk("reset_low_out", lo_out, PIN_VAL_RST);
    chk("reset_high_oe_n", hi_oe_n, PIN_OE_N_RST);
    chk("reset_handshake", {6'h00, cmd_ready, rsp_valid}, 8'h00);
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    $display("test reset done");
    // start, held, repeated start, held, stop; each step six times with random spare pins
    for (int s = 0; s < 11; s++) begin
      for (int r = 0; r < 6; r++) begin
        lfsr = lfsr_next(lfsr);
        wr(OP_WR_LOW, {lfsr[7:3], 3'h0}, {lfsr[15:11], seq[s]});
        chk("low_i2c_val", lo_out & 8'h07, 8'h00);
      end
      if (seq[s] == 3'h1) begin
        chk("scl_low_sda_released", lo_oe_n & 8'h03, 8'h02);
        lfsr = lfsr_next(lfsr);
        hi_ext = lfsr[15:8];
        wr(OP_WR_HIGH, lfsr[7:0], lfsr[15:8] ^ 8'h5A);
        rd(OP_RD_LOW, (ld & lv) | ~ld, 1'b1);
        chk("low_spare_pins", last_rsp & 8'hF8, ((ld & lv) | ~ld) & 8'hF8);
      end
    end
    $display("test start_stop done");
    for (k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      hi_ext = lfsr[7:0];
      wr(OP_WR_HIGH, lfsr[15:8], 8'(8'hF0 >> k));
      rd(OP_RD_HIGH, (hv & hd) | (hi_ext & ~hd), 1'b1);
    end
    $display("test high_port done");
    // no send-immediate: only the latency timer returns the byte
    rd(OP_RD_HIGH, (hv & hd) | (hi_ext & ~hd), 1'b0);
    $display("test latency done");
    send(8'h8F);
    cmd_valid = 1'b0;
    k = 0;
    // the pulse already stands when send returns, one step after the opcode edge
    repeat (4) begin
      if (bad_cmd === 1'b1) k++;
      @(posedge clk);
      #1;
    end
    chk("bad_cmd_cycles", 8'(k), 8'h01);
    $display("test bad_opcode done");
    wrap_up();
  end
endmodule
